// ===== src/phsbp_pkg.sv
package phsbp_pkg;
	localparam logic [3:0] CMD_SPECIAL   = 4'h1;
	localparam logic [3:0] CMD_CFG_RD    = 4'hA;
	localparam logic [3:0] CMD_CFG_WR    = 4'hB;
	localparam logic [1:0] IDX_ID        = 2'h0;
	localparam logic [1:0] IDX_CMDSTS    = 2'h1;
	localparam logic [1:0] IDX_SCR0      = 2'h2;
	localparam logic [1:0] IDX_SCR1      = 2'h3;
	localparam int         CMD_PAR_EN    = 6;
	localparam int         CMD_SERR_EN   = 8;
	localparam int         STS_SIG_SERR  = 14;
	localparam int         STS_DET_PERR  = 15;
	localparam logic [2:0] DEVSEL_WAIT_DEF = 3'h5;

	typedef enum logic [1:0] {TS_IDLE, TS_DEC, TS_DATA, TS_TURN} phsbp_tst_t;
	typedef enum logic [2:0] {MS_IDLE, MS_REQ, MS_ADDR, MS_DATA, MS_TURN} phsbp_mst_t;
	typedef enum logic [1:0] {PE_OFF, PE_LOW, PE_HIGH} phsbp_pe_t;

	typedef struct packed {
		logic [31:0] ad;
		logic [3:0]  cbe_n;
		logic        par;
		logic        frame_n;
		logic        irdy_n;
		logic        trdy_n;
		logic        devsel_n;
		logic        stop_n;
		logic        idsel;
		logic        gnt_n;
		logic        clkrun_n;
	} phsbp_bus_in_t;

	typedef struct packed {
		logic [31:0] ad;
		logic        ad_oe;
		logic [3:0]  cbe_n;
		logic        cbe_oe;
		logic        par;
		logic        par_oe;
		logic        frame_n;
		logic        frame_oe;
		logic        irdy_n;
		logic        irdy_oe;
		logic        trdy_n;
		logic        trdy_oe;
		logic        devsel_n;
		logic        devsel_oe;
		logic        stop_n;
		logic        stop_oe;
		logic        perr_n;
		logic        perr_oe;
		logic        serr_oe;
		logic        req_n;
		logic        req_oe;
		logic        clkrun_oe;
	} phsbp_bus_out_t;

	typedef struct packed {
		logic cb_mode;
		logic hs_pullup;
		logic st_pullup;
		logic st_pulldown;
	} phsbp_card_t;

	typedef struct packed {
		phsbp_tst_t     ts;
		phsbp_mst_t     ms;
		phsbp_pe_t      pe;
		phsbp_bus_out_t bo;
		phsbp_card_t    card;
		logic           fr;
		logic           pq;
		logic           achk;
		logic           dchk;
		logic [1:0]     idx;
		logic           twr;
		logic [15:0]    cmd;
		logic [15:0]    sts;
		logic [31:0]    scr0;
		logic [31:0]    scr1;
		logic [2:0]     dto;
		logic           mwr;
		logic [31:0]    maddr;
		logic [31:0]    mwd;
		logic [3:0]     mcmd;
		logic [3:0]     mbe_n;
		logic           busy;
		logic           done;
		logic           abort;
		logic [31:0]    rdata;
		logic           cprev;
		logic           cb;
	} phsbp_st_t;

	// All-zero: every enable released, machines idle, registers cleared
	localparam phsbp_st_t ST_RST = '0;
endpackage : phsbp_pkg

// ===== src/phsbp_top.sv
// Functional notes
// - A driver of a sustained line drives it high one clock before releasing it.
// - A new owner starts driving only a clock after the previous owner released.
// - All bus inputs are sampled on the rising bus clock edge.
// - Bus reset reinitialises state and tristates every output.
// - Global reset clears everything, including sticky status kept over bus reset.
// - Parity is even over the 32 address/data and 4 command lines.
// - Parity follows its address or data phase by exactly one clock.
// - Master drives parity for address and writes, target for reads.
// - Command lines carry the command at address, byte enables in data.
// - Master asserts frame to start, drops it entering the final phase.
// - A data phase completes only when both ready lines are sampled low.
// - Write data is valid with initiator ready, read data with target ready.
// - Target stop request ends the transaction; the master obeys.
// - Configuration cycles are claimed only while the select input is high.
// - Device select is driven on a claimed address and watched as master.
// - Write data parity errors pull the error line low; never special cycles.
// - Address parity error on either bus pulses system error for one clock.
// - Request the bus; master only after grant.
// - Clock-run is pulled low to ask for the clock when it is stopped.
// - Card pin functions follow the card type found at insertion.
// - Handshake pull-ups are on only in the 32-bit card mode.
// - Status input pull direction follows the inserted card type.
`timescale 1ns/1ns
module phsbp_top
	import phsbp_pkg::*;
#(
	parameter logic [31:0] ID_WORD     = 32'h0A5C_3E01, // Arbitrary identity value
	parameter logic [2:0]  DEVSEL_WAIT = DEVSEL_WAIT_DEF
)(
	input  wire logic           clock,            // Host bus clock
	input  wire logic           rst_n,            // Global reset
	input  wire logic           host_bus_reset_n, // Bus reset, synchronous
	input  wire phsbp_bus_in_t  bus_i,            // Sampled bus lines
	output phsbp_bus_out_t      bus_o,            // Bus drive values and enables
	input  wire logic           m_req,            // Start a master transfer
	input  wire logic [31:0]    m_addr,           // Master address
	input  wire logic [3:0]     m_cmd,            // Master command
	input  wire logic [31:0]    m_wdata,          // Master write data
	input  wire logic [3:0]     m_be_n,           // Master byte enables
	output logic                m_busy,           // Master transfer in progress
	output logic                m_done,           // Master transfer finished
	output logic                m_abort,          // Last transfer not completed
	output logic [31:0]         m_rdata,          // Master read data
	output logic [15:0]         cfg_command,      // Command register
	input  wire logic           card_present,     // Card detected
	input  wire logic           card_is_cardbus,  // Card type at detection
	input  wire logic           card_addr_perr,   // Card-side address parity error
	output phsbp_card_t         card_o            // Card pin mode controls
);

	generate
		if (DEVSEL_WAIT == 3'h0)
		begin : g_bad_wait
			$error("DEVSEL_WAIT must be at least one");
		end
	endgenerate

	phsbp_st_t q;
	phsbp_st_t d;

	function automatic logic [31:0] be_mask(input logic [3:0] be_n);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++)
		begin
			m[i*8 +: 8] = {8{~be_n[i]}};
		end
		return m;
	endfunction : be_mask

	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be_n);
		return (old_v & ~be_mask(be_n)) | (new_v & be_mask(be_n));
	endfunction : be_merge

	logic        aph;
	logic [31:0] rd_val;
	logic [31:0] wmask;
	logic        dperr;
	logic [31:0] cmd_new;

	always_comb
	begin
		aph    = !bus_i.frame_n && q.fr && !q.bo.frame_oe;
		wmask  = be_mask(bus_i.cbe_n);
		dperr  = q.dchk && (bus_i.par != q.pq);
		cmd_new = be_merge({16'h0000, q.cmd}, bus_i.ad, bus_i.cbe_n);
		rd_val = ID_WORD;
		if (q.idx == IDX_CMDSTS)
		begin
			rd_val = {q.sts, q.cmd};
		end
		else if (q.idx == IDX_SCR0)
		begin
			rd_val = q.scr0;
		end
		else if (q.idx == IDX_SCR1)
		begin
			rd_val = q.scr1;
		end

		d = q;
		d.done = 1'b0;
		d.dchk = 1'b0;
		d.bo.serr_oe = 1'b0;
		d.bo.req_oe = 1'b1;
		d.fr = bus_i.frame_n;
		d.achk = aph;

		// Parity over what is on the bus this cycle, shown next cycle
		d.pq = ^{bus_i.ad, bus_i.cbe_n};
		d.bo.par = ^{q.bo.ad_oe ? q.bo.ad : bus_i.ad, q.bo.cbe_oe ? q.bo.cbe_n : bus_i.cbe_n};
		d.bo.par_oe = q.bo.ad_oe;

		// Card pin modes; the type is held from insertion, not tracked live
		d.cprev = card_present;
		if (!card_present)
		begin
			d.cb = 1'b0;
		end
		else if (!q.cprev)
		begin
			d.cb = card_is_cardbus;
		end
		d.card.cb_mode = d.cb;
		d.card.hs_pullup = card_present && d.cb;
		d.card.st_pullup = card_present && !d.cb;
		d.card.st_pulldown = card_present && d.cb;

		// Target: configuration space only, one data phase then disconnect
		case (q.ts)
			TS_IDLE:
			begin
				if (aph && bus_i.idsel && bus_i.ad[1:0] == 2'h0 &&
					(bus_i.cbe_n == CMD_CFG_RD || bus_i.cbe_n == CMD_CFG_WR))
				begin
					d.ts = TS_DEC;
					d.idx = bus_i.ad[3:2];
					d.twr = (bus_i.cbe_n == CMD_CFG_WR);
					d.bo.devsel_n = 1'b0;
					d.bo.devsel_oe = 1'b1;
					d.bo.trdy_n = 1'b1;
					d.bo.trdy_oe = 1'b1;
					d.bo.stop_n = 1'b1;
					d.bo.stop_oe = 1'b1;
				end
			end
			TS_DEC:
			begin
				// Address lines left idle one clock for turnaround on reads
				d.ts = TS_DATA;
				d.bo.trdy_n = 1'b0;
				d.bo.stop_n = 1'b0;
				if (!q.twr)
				begin
					d.bo.ad = rd_val;
					d.bo.ad_oe = 1'b1;
				end
			end
			TS_DATA:
			begin
				if (!bus_i.irdy_n)
				begin
					if (q.twr)
					begin
						d.dchk = 1'b1;
						if (q.idx == IDX_CMDSTS)
						begin
							// Upper half belongs to status, which clears by its own rule
							d.cmd = cmd_new[15:0];
							d.sts = q.sts & ~(bus_i.ad[31:16] & wmask[31:16]);
						end
						else if (q.idx == IDX_SCR0)
						begin
							d.scr0 = be_merge(q.scr0, bus_i.ad, bus_i.cbe_n);
						end
						else if (q.idx == IDX_SCR1)
						begin
							d.scr1 = be_merge(q.scr1, bus_i.ad, bus_i.cbe_n);
						end
					end
					d.ts = TS_TURN;
					d.bo.devsel_n = 1'b1;
					d.bo.trdy_n = 1'b1;
					d.bo.stop_n = 1'b1;
					d.bo.ad_oe = 1'b0;
				end
			end
			TS_TURN:
			begin
				d.ts = TS_IDLE;
				d.bo.devsel_oe = 1'b0;
				d.bo.trdy_oe = 1'b0;
				d.bo.stop_oe = 1'b0;
			end
			default:
			begin
				d.ts = TS_IDLE;
			end
		endcase

		// Master: single data phase per request
		case (q.ms)
			MS_IDLE:
			begin
				// Reset leaves the request low; idle must not ask for the bus
				d.bo.req_n = 1'b1;
				if (m_req)
				begin
					d.ms = MS_REQ;
					d.busy = 1'b1;
					d.maddr = m_addr;
					d.mcmd = m_cmd;
					d.mwd = m_wdata;
					d.mbe_n = m_be_n;
					d.mwr = m_cmd[0];
					d.bo.req_n = 1'b0;
				end
			end
			MS_REQ:
			begin
				d.bo.clkrun_oe = bus_i.clkrun_n;
				// Idle bus with grant: previous owner has let go
				if (!bus_i.gnt_n && bus_i.frame_n && bus_i.irdy_n && q.ts == TS_IDLE)
				begin
					d.ms = MS_ADDR;
					d.bo.clkrun_oe = 1'b0;
					d.bo.req_n = 1'b1;
					d.bo.frame_n = 1'b0;
					d.bo.frame_oe = 1'b1;
					d.bo.ad = q.maddr;
					d.bo.ad_oe = 1'b1;
					d.bo.cbe_n = q.mcmd;
					d.bo.cbe_oe = 1'b1;
				end
			end
			MS_ADDR:
			begin
				d.ms = MS_DATA;
				d.dto = 3'h0;
				d.bo.frame_n = 1'b1;
				d.bo.irdy_n = 1'b0;
				d.bo.irdy_oe = 1'b1;
				d.bo.cbe_n = q.mbe_n;
				d.bo.ad = q.mwd;
				d.bo.ad_oe = q.mwr;
			end
			MS_DATA:
			begin
				d.dto = q.dto + 3'h1;
				if (!bus_i.trdy_n || !bus_i.stop_n ||
					(bus_i.devsel_n && q.dto == DEVSEL_WAIT))
				begin
					d.ms = MS_TURN;
					d.done = 1'b1;
					d.busy = 1'b0;
					d.abort = bus_i.trdy_n;
					d.rdata = bus_i.ad;
					d.bo.frame_oe = 1'b0;
					d.bo.irdy_n = 1'b1;
					d.bo.ad_oe = 1'b0;
					d.bo.cbe_oe = 1'b0;
				end
			end
			MS_TURN:
			begin
				d.ms = MS_IDLE;
				d.bo.irdy_oe = 1'b0;
			end
			default:
			begin
				d.ms = MS_IDLE;
			end
		endcase

		// Error reporting after register writes so a hardware set wins
		if ((q.achk && bus_i.par != q.pq) || card_addr_perr)
		begin
			d.sts[STS_DET_PERR] = 1'b1;
			if (q.cmd[CMD_SERR_EN] && (q.cmd[CMD_PAR_EN] || card_addr_perr))
			begin
				d.bo.serr_oe = 1'b1;
				d.sts[STS_SIG_SERR] = 1'b1;
			end
		end
		case (q.pe)
			PE_OFF:
			begin
				if (dperr)
				begin
					d.sts[STS_DET_PERR] = 1'b1;
					if (q.cmd[CMD_PAR_EN])
					begin
						d.pe = PE_LOW;
						d.bo.perr_n = 1'b0;
						d.bo.perr_oe = 1'b1;
					end
				end
			end
			PE_LOW:
			begin
				d.pe = PE_HIGH;
				d.bo.perr_n = 1'b1;
			end
			default:
			begin
				d.pe = PE_OFF;
				d.bo.perr_oe = 1'b0;
			end
		endcase

		// Bus reset: release everything, keep sticky status for global reset
		if (!host_bus_reset_n)
		begin
			d = ST_RST;
			d.sts = q.sts;
			d.fr = 1'b1;
		end
	end

	// Bus lines arrive synchronous and are sampled here on the rising edge
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= ST_RST;
		end
		else
		begin
			q <= d;
		end
	end

	assign bus_o       = q.bo;
	assign card_o      = q.card;
	assign m_busy      = q.busy;
	assign m_done      = q.done;
	assign m_abort     = q.abort;
	assign m_rdata     = q.rdata;
	assign cfg_command = q.cmd;

endmodule : phsbp_top

// ===== tb/phsbp_host_model.sv
`timescale 1ns/1ns
module phsbp_host_model
	import phsbp_pkg::*;
(
	input  wire logic           clock,   // Bus clock
	input  wire logic           rst_n,   // Reset
	input  wire phsbp_bus_out_t dev,     // Device drive
	input  wire logic [1:0]     mode,    // 0 normal, 1 no claim, 2 stop
	input  wire logic [31:0]    rd_word, // Read data returned
	output phsbp_bus_in_t       hm       // Arbiter and target lines
);
	logic [2:0] cnt;
	logic       act;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hm  <= '1;
			act <= 1'b0;
			cnt <= 3'h0;
		end
		else
		begin
			hm.gnt_n <= !(dev.req_oe && !dev.req_n);
			hm.ad    <= ~hm.ad; // Idle lines never look stable
			cnt      <= cnt + 3'h1;
			if (!act)
			begin
				act <= dev.frame_oe && !dev.frame_n;
				cnt <= 3'h0;
			end
			else
			begin
				hm.devsel_n <= mode == 2'h1;
				if (cnt == 3'h1)
				begin
					hm.trdy_n <= mode != 2'h0;
					hm.stop_n <= mode != 2'h2;
					hm.ad     <= rd_word;
				end
				if (!hm.trdy_n && !dev.irdy_n || !hm.stop_n || cnt == 3'h7)
				begin
					act         <= 1'b0;
					hm.devsel_n <= 1'b1;
					hm.trdy_n   <= 1'b1;
					hm.stop_n   <= 1'b1;
				end
			end
		end
	end
endmodule : phsbp_host_model

// ===== tb/phsbp_properties.sv
`timescale 1ns/1ns
module phsbp_properties
	import phsbp_pkg::*;
(
	input wire logic           clock,            // Bus clock
	input wire logic           rst_n,            // Global reset
	input wire logic           host_bus_reset_n, // Bus reset
	input wire phsbp_bus_in_t  bus_i,            // Bus lines seen
	input wire phsbp_bus_out_t bus_o,            // Bus drive
	input wire phsbp_card_t    card_o            // Card pin controls
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_reset_releases_all:
		assert property (!host_bus_reset_n |=> !(bus_o.ad_oe | bus_o.frame_oe | bus_o.irdy_oe
			| bus_o.trdy_oe | bus_o.devsel_oe | bus_o.req_oe | bus_o.serr_oe | bus_o.par_oe
			| bus_o.cbe_oe | bus_o.stop_oe | bus_o.perr_oe | bus_o.clkrun_oe))
		else $error("output driven in bus reset");
	a_addr_parity:
		assert property (bus_o.frame_oe && !bus_o.frame_n |=> bus_o.par_oe
			&& bus_o.par == ^{$past(bus_o.ad), $past(bus_o.cbe_n)})
		else $error("bad address parity");
	a_read_parity:
		assert property (bus_o.trdy_oe && !bus_o.trdy_n && bus_o.ad_oe && !bus_i.irdy_n |=> bus_o.par_oe
			&& bus_o.par == ^{$past(bus_o.ad), $past(bus_i.cbe_n)})
		else $error("bad read parity");
	a_trdy_waits_irdy:
		assert property (bus_o.trdy_oe && !bus_o.trdy_n && bus_i.irdy_n |=> bus_o.trdy_oe && !bus_o.trdy_n)
		else $error("target ready dropped early");
	a_serr_one_clock:
		assert property ($rose(bus_o.serr_oe) |=> !bus_o.serr_oe)
		else $error("system error not one clock");
	a_grant_before_frame:
		assert property ($rose(bus_o.frame_oe) |-> !$past(bus_i.gnt_n))
		else $error("frame without grant");
	a_claim_needs_select:
		assert property ($rose(bus_o.devsel_oe) |-> $past(bus_i.idsel) && !$past(bus_i.frame_n))
		else $error("claim without select");
	a_frame_high_release:
		assert property ($fell(bus_o.frame_oe) && $past(host_bus_reset_n) |-> $past(bus_o.frame_n))
		else $error("frame released low");
	a_perr_pulse:
		assert property (bus_o.perr_oe && !bus_o.perr_n |=> bus_o.perr_oe && bus_o.perr_n)
		else $error("parity error not driven high");
	a_pullup_mode:
		assert property (card_o.hs_pullup == card_o.cb_mode)
		else $error("pull-up outside 32-bit mode");
	a_clkrun_request:
		assert property (host_bus_reset_n && bus_o.req_oe && !bus_o.req_n && bus_i.gnt_n && bus_i.clkrun_n
			|=> bus_o.clkrun_oe)
		else $error("clock not requested while waiting");
endmodule : phsbp_properties

// ===== tb/tb_pci_host_side_bus_port.sv
`timescale 1ns/1ns
module tb_pci_host_side_bus_port;
	import phsbp_pkg::*;
	typedef struct packed {logic full; logic [32:0] v;} phsbp_exp_t;
	localparam logic [31:0] ID = 32'h0BAD_F00D; // Arbitrary identity value
	logic           clock = 0, rst_n = 0, hbr_n = 0, m_req = 0, cp = 0, ccb = 0, cperr = 0;
	logic           m_busy, m_done, m_abort;
	logic [31:0]    m_addr = '0, m_wdata = '0, m_rdata, x, y;
	logic [3:0]     m_cmd = '0;
	logic [1:0]     mode = '0;
	logic [15:0]    cfg_command;
	phsbp_bus_in_t  bi = '1, hm, bus_i;
	phsbp_bus_out_t bus_o;
	phsbp_card_t    card_o;
	phsbp_exp_t     q[$], e;
	int             error_cnt = 0, samples_checked = 0, seed = 32'h38c1, serrs = 0, perrs = 0, n;

	phsbp_top #(.ID_WORD(ID)) u_phsbp_top (.clock, .rst_n, .host_bus_reset_n(hbr_n), .bus_i, .bus_o, .m_req,
		.m_addr, .m_cmd, .m_wdata, .m_be_n(4'h0), .m_busy, .m_done, .m_abort, .m_rdata, .cfg_command,
		.card_present(cp), .card_is_cardbus(ccb), .card_addr_perr(cperr), .card_o);
	phsbp_host_model u_phsbp_host_model (.clock, .rst_n, .dev(bus_o), .mode, .rd_word(m_wdata), .hm);

	always #50 clock = ~clock;

	always_comb
	begin
		bus_i          = bi;
		bus_i.gnt_n    = hm.gnt_n;
		bus_i.ad       = bus_o.ad_oe ? bus_o.ad : (!hm.trdy_n ? hm.ad : bi.ad);
		bus_i.cbe_n    = bus_o.cbe_oe ? bus_o.cbe_n : bi.cbe_n;
		bus_i.par      = bus_o.par_oe ? bus_o.par : bi.par;
		bus_i.frame_n  = bus_o.frame_oe ? bus_o.frame_n : bi.frame_n;
		bus_i.irdy_n   = bus_o.irdy_oe ? bus_o.irdy_n : bi.irdy_n;
		bus_i.trdy_n   = bus_o.trdy_oe ? bus_o.trdy_n : hm.trdy_n;
		bus_i.devsel_n = bus_o.devsel_oe ? bus_o.devsel_n : hm.devsel_n;
		bus_i.stop_n   = bus_o.stop_oe ? bus_o.stop_n : hm.stop_n;
		bus_i.clkrun_n = bi.clkrun_n & !bus_o.clkrun_oe;
	end

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict;
		$display("Counts: %0d checked, %0d mismatched", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	// Results land in order, so one queue serves target reads and master completions
	always @(posedge clock)
	begin
		serrs += bus_o.serr_oe;
		perrs += bus_o.perr_oe & !bus_o.perr_n;
		if (m_done === 1'b1 || bus_o.trdy_oe && !bus_o.trdy_n && bus_o.ad_oe && !bus_i.irdy_n)
		begin
			e = q.pop_front();
			check(m_done ? {m_abort, m_rdata & {32{e.full}}} : {1'b0, bus_o.ad}, e.v);
		end
	end

	task automatic cfg(input logic [3:0] c, input logic [1:0] i, input logic [3:0] be, input logic [31:0] d,
		input logic s, input logic [1:0] bad);
		@(negedge clock);
		bi.frame_n = 0;
		bi.idsel = s;
		bi.ad = {28'h0, i, 2'h0};
		bi.cbe_n = c;
		@(negedge clock);
		bi.par = ^{bi.ad, bi.cbe_n} ^ bad[1];
		bi.frame_n = !c[0];
		bi.irdy_n = !c[0];
		bi.idsel = 0;
		bi.cbe_n = be;
		bi.ad = c[0] ? d : ~bi.ad;
		@(negedge clock);
		bi.par = ^{bi.ad, be} ^ bad[0];
		for (n = 0; n < 8 && bus_i.trdy_n; n++)
			@(negedge clock);
		if (n == 8 && s && (c == CMD_CFG_RD || c == CMD_CFG_WR))
		begin
			error_cnt++;
			print_verdict();
		end
		// One wait state on reads so target ready must hold for initiator ready
		if (!c[0])
			@(negedge clock);
		bi.frame_n = 1;
		bi.irdy_n = 0;
		@(negedge clock);
		bi.irdy_n = 1;
		@(negedge clock);
	endtask : cfg

	task automatic mst(input logic [3:0] c, input logic [1:0] md, input phsbp_exp_t ex);
		@(negedge clock);
		mode = md;
		m_cmd = c;
		m_addr = $random(seed);
		m_wdata = ex.v[31:0];
		m_req = 1;
		q.push_back(ex);
		@(negedge clock);
		m_req = 0;
		for (n = 0; n < 40 && m_busy !== 1'b0; n++)
			@(negedge clock);
		if (n == 40)
		begin
			error_cnt++;
			print_verdict();
		end
	endtask : mst

	initial
	begin
		bi.idsel = 0;
		x = $random(seed);
		y = $random(seed);
		repeat (16) @(negedge clock);
		rst_n = 1;
		hbr_n = 1;
		@(negedge clock);
		check({bus_o.req_oe, bus_o.req_n}, 2'b11);
		q.push_back({2'b10, ID});
		cfg(CMD_CFG_RD, IDX_ID, 4'h0, 0, 1, 0);
		cfg(CMD_CFG_WR, IDX_SCR0, 4'h0, x, 1, 0);
		cfg(CMD_CFG_WR, IDX_SCR0, 4'hA, y, 1, 0);
		q.push_back({2'b10, x[31:24], y[23:16], x[15:8], y[7:0]});
		cfg(CMD_CFG_RD, IDX_SCR0, 4'h0, 0, 1, 0);
		cfg(CMD_CFG_RD, IDX_SCR1, 4'h0, 0, 0, 0);
		check(n, 8);
		$display("Test config access done");
		cfg(CMD_CFG_WR, IDX_CMDSTS, 4'h0, 32'h0000_0140, 1, 0);
		check(cfg_command, 16'h0140);
		cfg(CMD_CFG_WR, IDX_SCR1, 4'h0, y, 1, 2'b01);
		cfg(CMD_SPECIAL, IDX_SCR1, 4'h0, y, 1, 2'b01);
		cfg(CMD_CFG_WR, IDX_SCR1, 4'h0, y, 1, 2'b10);
		cperr = 1;
		@(negedge clock);
		cperr = 0;
		repeat (3) @(negedge clock);
		check(perrs, 1);
		check(serrs, 2);
		q.push_back({2'b10, 32'hC000_0140});
		cfg(CMD_CFG_RD, IDX_CMDSTS, 4'h0, 0, 1, 0);
		hbr_n = 0;
		repeat (2) @(negedge clock);
		hbr_n = 1;
		@(negedge clock);
		q.push_back({2'b10, 32'hC000_0000});
		cfg(CMD_CFG_RD, IDX_CMDSTS, 4'h0, 0, 1, 0);
		rst_n = 0;
		@(negedge clock);
		rst_n = 1;
		@(negedge clock);
		q.push_back({2'b10, 32'h0});
		cfg(CMD_CFG_RD, IDX_CMDSTS, 4'h0, 0, 1, 0);
		$display("Test errors and resets done");
		mst(4'h7, 0, {2'b10, x});
		mst(4'h6, 0, {2'b10, y});
		mst(4'h6, 1, {2'b01, 32'h0});
		mst(4'h7, 2, {2'b01, 32'h0});
		$display("Test master transfers done");
		ccb = 1;
		cp = 1;
		repeat (2) @(negedge clock);
		check(card_o, 4'b1101);
		cp = 0;
		ccb = 0;
		@(negedge clock);
		cp = 1;
		repeat (2) @(negedge clock);
		check(card_o, 4'b0010);
		ccb = 1;
		repeat (2) @(negedge clock);
		check(card_o, 4'b0010);
		$display("Test card modes done");
		print_verdict();
	end
endmodule : tb_pci_host_side_bus_port

bind phsbp_top phsbp_properties u_phsbp_properties (.clock, .rst_n, .host_bus_reset_n, .bus_i, .bus_o, .card_o);
